// [design/ufcb_pkg.sv]
package ufcb_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DATA = 8'h20;
    localparam logic [7:0] IDX_DIV0_LO = 8'h21;
    localparam logic [7:0] IDX_DIV0_HI = 8'h22;
    localparam logic [7:0] IDX_DETECT = 8'h23;
    localparam logic [7:0] IDX_FRAME = 8'h24;
    localparam logic [7:0] IDX_XFER = 8'h25;
    localparam logic [7:0] IDX_STATUS = 8'h26;
    localparam logic [7:0] IDX_DIV1_LO = 8'h74;
    localparam logic [7:0] IDX_DIV1_HI = 8'h75;
    localparam int IDX_LSB = 2;
    localparam int MAP_BITS = 10;

    localparam logic [7:0] FRAME_RST = 8'h06;
    localparam logic [7:0] REG_RST = 8'h00;

    localparam int FRM_CPOL = 0;
    localparam int FRM_CPHA = 1;
    localparam int FRM_ORDER = 2;
    localparam int FRM_STOP = 3;
    localparam int FRM_PODD = 4;
    localparam int FRM_PEN = 5;
    localparam int XF_TXB8 = 0;
    localparam int XF_SIZE2 = 2;
    localparam int XF_TXEN = 3;
    localparam int XF_RXEN = 4;
    localparam int XF_RXCIE = 7;
    localparam int ST_TXC = 6;
    localparam int SD_SFDE = 5;
    localparam int SD_RXS = 6;
    localparam int SD_RXSIE = 7;

    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_SPI = 2'h3;
    localparam logic [3:0] SPI_BITS = 4'h8;
    localparam logic [4:0] SPI_TICKS = 5'h10;

    typedef enum logic {RX_IDLE, RX_BUSY} ufcb_rx_state_t;

    function automatic logic [3:0] ufcb_char_bits(input logic [2:0] code);
        case (code)
            3'h0: return 4'h5;
            3'h1: return 4'h6;
            3'h2: return 4'h7;
            3'h7: return 4'h9;
            default: return 4'h8;
        endcase
    endfunction : ufcb_char_bits

    function automatic logic ufcb_parity(input logic [8:0] d,
            input logic [3:0] n, input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                p = p ^ d[i];
            end
        end
        return p;
    endfunction : ufcb_parity
endpackage : ufcb_pkg

// [design/ufcb_top.sv]
// Behaviour
// - mode field 00 async, 01 sync, 11 master SPI, 10 reserved.
// - parity 00 off, 10 even, 11 odd; transmitter appends parity bit.
// - receiver checks parity and sets parity error on mismatch.
// - stop select gives one or two transmitted stop bits; receiver ignores.
// - three-bit size code gives 5 to 8 or 9 data bits.
// - sync mode changes data on one clock edge, samples on the other.
// - start detection sets start flag; cleared only by writing one.
// - start irq only when its enable, global enable and flag set.
// - start frame detector watches idle-to-start fall and wakes processor.
// - start and complete enables choose wake sources when detector on.
// - low five bits of start detect register read zero.
// - twelve-bit divisor split as four high and eight low bits.
// - writing low divisor byte reloads the prescaler at once.
// - SPI mode drops parity and uart control for common transfer control.
// - master bit rate is clock over twice divisor plus one.
// - SPI transfer clock can reach half the system clock.
// - SPI has four clock modes, bit order and queued transfers.
// - receive complete flag follows unread data; disable flushes it.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
module ufcb_top import ufcb_pkg::*; #(
    parameter int ADDR_W = 12
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic HSEL_I,
    input wire logic [ADDR_W-1:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic RXD_I,
    output logic TXD_O,
    output logic XCK_O,
    output logic XCK_OE_O,
    input wire logic XCK_DIR_I,
    input wire logic GLOBAL_IRQ_EN_I,
    output logic RX_START_IRQ_O,
    output logic RX_COMPLETE_IRQ_O,
    output logic WAKE_O,
    output logic BAUD1_TICK_O
);
    logic dp_wr_r, dp_rd_r, dp_ok_r;
    logic [7:0] dp_idx_r, rd_byte;
    logic [7:0] frame_r;
    logic rxcie_r, rxen_r, txen_r, size2_r, txb8_r;
    logic rxsie_r, rxs_r, sfde_r, txc_r;
    logic [7:0] div_lo_r [2];
    logic [3:0] div_hi_r [2];
    logic [11:0] cnt_r [2];
    logic [1:0] wr_lo, wr_hi;
    logic wr_sel, wr_frame, wr_xfer, wr_det, wr_data, wr_stat, rd_data;
    logic spi, sync, asyn, uart_on, par_en, cpha, tick, phase_r;
    logic shift_ev, samp_ev, samp;
    logic [3:0] nbits, tx_len, rx_total, rx_cnt_r, rx_idx;
    logic [8:0] tx_buf_r, rx_sh_r, rx_word, rx_data_r;
    logic [7:0] spi_bits;
    logic [12:0] tx_sh_r, tx_frame;
    logic [4:0] tx_left_r;
    logic tx_full_r, txd_r, tx_load, tx_done;
    logic rx_s1_r, rx_s2_r, rx_s3_r, rx_f_r, rx_fall, rx_ph_r;
    logic rx_pbit_r, rx_valid_r, rx_perr_r, rx_push, rx_false;
    ufcb_rx_state_t rx_state_r;

    // bus slave: zero wait states, always OKAY
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            dp_wr_r <= 1'b0;
            dp_rd_r <= 1'b0;
            dp_ok_r <= 1'b0;
            dp_idx_r <= 8'h00;
        end else begin
            dp_wr_r <= HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I &&
                       HSIZE_I == 3'h2;
            dp_rd_r <= HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;
            dp_ok_r <= HADDR_I[1:0] == 2'h0 && (HADDR_I >> MAP_BITS) == '0;
            dp_idx_r <= HADDR_I[IDX_LSB +: 8];
        end
    end

    assign wr_sel = dp_wr_r && dp_ok_r;
    assign wr_frame = wr_sel && dp_idx_r == IDX_FRAME;
    assign wr_xfer = wr_sel && dp_idx_r == IDX_XFER;
    assign wr_det = wr_sel && dp_idx_r == IDX_DETECT;
    assign wr_data = wr_sel && dp_idx_r == IDX_DATA;
    assign wr_stat = wr_sel && dp_idx_r == IDX_STATUS;
    assign wr_lo = {wr_sel && dp_idx_r == IDX_DIV1_LO,
                    wr_sel && dp_idx_r == IDX_DIV0_LO};
    assign wr_hi = {wr_sel && dp_idx_r == IDX_DIV1_HI,
                    wr_sel && dp_idx_r == IDX_DIV0_HI};
    assign rd_data = dp_rd_r && dp_ok_r && dp_idx_r == IDX_DATA;

    always_comb begin
        case (dp_idx_r)
            IDX_DATA: rd_byte = rx_data_r[7:0];
            IDX_DIV0_LO: rd_byte = div_lo_r[0];
            IDX_DIV0_HI: rd_byte = {4'h0, div_hi_r[0]};
            IDX_DIV1_LO: rd_byte = div_lo_r[1];
            IDX_DIV1_HI: rd_byte = {4'h0, div_hi_r[1]};
            IDX_DETECT: rd_byte = {rxsie_r, rxs_r, sfde_r, 5'h00};
            IDX_FRAME: rd_byte = frame_r;
            IDX_XFER: rd_byte = {rxcie_r, 2'h0, rxen_r, txen_r, size2_r,
                                 rx_data_r[8], txb8_r};
            IDX_STATUS: rd_byte = {rx_valid_r, txc_r, !tx_full_r, 2'h0,
                                   rx_perr_r, 2'h0};
            default: rd_byte = 8'h00;
        endcase
    end
    assign HRDATA_O = (dp_rd_r && dp_ok_r) ? {24'h00_0000, rd_byte} : '0;

    // software-written control state
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            frame_r <= FRAME_RST;
            {rxcie_r, rxen_r, txen_r, size2_r, txb8_r} <= 5'h00;
            {rxsie_r, sfde_r} <= 2'h0;
            div_lo_r <= '{default: REG_RST};
            div_hi_r <= '{default: 4'h0};
        end else begin
            if (wr_frame) begin
                frame_r <= HWDATA_I[7:0];
            end
            if (wr_xfer) begin
                rxcie_r <= HWDATA_I[XF_RXCIE];
                rxen_r <= HWDATA_I[XF_RXEN];
                txen_r <= HWDATA_I[XF_TXEN];
                size2_r <= HWDATA_I[XF_SIZE2];
                txb8_r <= HWDATA_I[XF_TXB8];
            end
            if (wr_det) begin
                rxsie_r <= HWDATA_I[SD_RXSIE];
                sfde_r <= HWDATA_I[SD_SFDE];
            end
            for (int c = 0; c < 2; c++) begin
                if (wr_lo[c]) begin
                    div_lo_r[c] <= HWDATA_I[7:0];
                end
                if (wr_hi[c]) begin
                    div_hi_r[c] <= HWDATA_I[3:0];
                end
            end
        end
    end

    // mode decode; code 10 runs neither engine
    assign spi = frame_r[7:6] == MODE_SPI;
    assign sync = frame_r[7:6] == MODE_SYNC;
    assign asyn = frame_r[7:6] == MODE_ASYNC;
    assign uart_on = asyn || sync;
    assign par_en = !spi && frame_r[FRM_PEN];
    assign cpha = frame_r[FRM_CPHA];
    assign nbits = spi ? SPI_BITS
                       : ufcb_char_bits({size2_r, frame_r[2:1]});

    // baud prescalers; channel 1 only supplies its tick
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            cnt_r <= '{default: 12'h000};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wr_lo[c]) begin
                    cnt_r[c] <= {div_hi_r[c], HWDATA_I[7:0]};
                end else if (cnt_r[c] == 12'h000) begin
                    cnt_r[c] <= {div_hi_r[c], div_lo_r[c]};
                end else begin
                    cnt_r[c] <= cnt_r[c] - 12'h001;
                end
            end
        end
    end
    assign tick = cnt_r[0] == 12'h000;
    assign BAUD1_TICK_O = cnt_r[1] == 12'h000;

    // ticks alternate the clock phase: two ticks per bit
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            phase_r <= 1'b0;
        end else if (spi && tx_left_r == 5'h00) begin
            phase_r <= 1'b0;
        end else if (tick) begin
            phase_r <= !phase_r;
        end
    end
    assign shift_ev = tick && !(phase_r ^ (spi && !cpha));
    assign samp_ev = tick && (phase_r ^ (spi && !cpha));
    assign XCK_O = (sync || (spi && tx_left_r != 5'h00)) ?
                   phase_r ^ frame_r[FRM_CPOL] : frame_r[FRM_CPOL];
    assign XCK_OE_O = XCK_DIR_I && (sync || spi);

    // transmit frame image after the start bit, lsb first
    always_comb begin
        tx_frame = '1;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < nbits) begin
                tx_frame[i] = tx_buf_r[i];
            end
        end
        if (par_en) begin
            tx_frame[nbits] = ufcb_parity(tx_buf_r, nbits,
                                          frame_r[FRM_PODD]);
        end
        tx_len = 4'h2 + nbits + {3'h0, par_en} +
                 {3'h0, frame_r[FRM_STOP]};
        spi_bits = tx_buf_r[7:0];
        if (!frame_r[FRM_ORDER]) begin
            spi_bits = {<<{tx_buf_r[7:0]}};
        end
    end

    assign tx_load = txen_r && tx_full_r &&
                     ((uart_on && shift_ev && tx_left_r <= 5'h01) ||
                      (spi && tx_left_r == 5'h00));
    assign tx_done = !tx_full_r && tx_left_r == 5'h01 &&
                     ((uart_on && shift_ev) || (spi && tick));

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            tx_sh_r <= '1;
            tx_left_r <= 5'h00;
            txd_r <= 1'b1;
        end else if (tx_load && spi) begin
            tx_left_r <= SPI_TICKS;
            tx_sh_r <= cpha ? {5'h1f, spi_bits} : {6'h3f, spi_bits[7:1]};
            if (!cpha) begin
                txd_r <= spi_bits[0];
            end
        end else if (tx_load) begin
            txd_r <= 1'b0;
            tx_sh_r <= tx_frame;
            tx_left_r <= 5'(tx_len);
        end else if (spi) begin
            if (tx_left_r != 5'h00 && tick) begin
                tx_left_r <= tx_left_r - 5'h01;
            end
            if (tx_left_r != 5'h00 && shift_ev) begin
                txd_r <= tx_sh_r[0];
                tx_sh_r <= {1'b1, tx_sh_r[12:1]};
            end
        end else if (uart_on && shift_ev) begin
            if (tx_left_r > 5'h01) begin
                txd_r <= tx_sh_r[0];
                tx_sh_r <= {1'b1, tx_sh_r[12:1]};
                tx_left_r <= tx_left_r - 5'h01;
            end else begin
                txd_r <= 1'b1;
                tx_left_r <= 5'h00;
            end
        end
    end
    assign TXD_O = txd_r;

    // one-entry queue in front of the shifter
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            tx_full_r <= 1'b0;
            tx_buf_r <= 9'h000;
            txc_r <= 1'b0;
        end else begin
            if (wr_data && txen_r && !tx_full_r) begin
                tx_buf_r <= {txb8_r, HWDATA_I[7:0]};
            end
            tx_full_r <= (wr_data && txen_r && !tx_full_r) ||
                         (tx_full_r && !tx_load);
            txc_r <= tx_done || (txc_r && !(wr_stat && HWDATA_I[ST_TXC]));
        end
    end

    // receive line: three stages, change taken when last two agree
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            {rx_s1_r, rx_s2_r, rx_s3_r, rx_f_r} <= 4'hf;
        end else begin
            rx_s1_r <= RXD_I;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
            if (rx_s2_r == rx_s3_r) begin
                rx_f_r <= rx_s3_r;
            end
        end
    end
    assign rx_fall = rx_f_r && rx_s2_r == rx_s3_r && !rx_s3_r;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            rxs_r <= 1'b0;
        end else begin
            rxs_r <= (rx_fall && (rxen_r || sfde_r)) ||
                     (rxs_r && !(wr_det && HWDATA_I[SD_RXS]));
        end
    end

    assign samp = asyn ? tick && !rx_ph_r : samp_ev;
    assign rx_total = spi ? SPI_BITS : 4'h2 + nbits + {3'h0, par_en};
    assign rx_idx = spi ? (frame_r[FRM_ORDER] ? rx_cnt_r : 4'h7 - rx_cnt_r)
                        : rx_cnt_r - 4'h1;
    assign rx_false = !spi && rx_cnt_r == 4'h0 && rx_f_r;
    assign rx_push = rx_state_r == RX_BUSY && samp && !rx_false &&
                     rx_cnt_r == rx_total - 4'h1;
    always_comb begin
        rx_word = rx_sh_r;
        if (spi) begin
            rx_word[rx_idx] = rx_f_r;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            rx_state_r <= RX_IDLE;
            rx_cnt_r <= 4'h0;
            rx_ph_r <= 1'b0;
            rx_sh_r <= 9'h000;
            rx_pbit_r <= 1'b0;
        end else if (!rxen_r) begin
            rx_state_r <= RX_IDLE;
        end else if (tx_load && spi) begin
            rx_state_r <= RX_BUSY;
            rx_cnt_r <= 4'h0;
            rx_sh_r <= 9'h000;
        end else begin
            unique case (rx_state_r)
                RX_IDLE: begin
                    rx_ph_r <= 1'b0;
                    rx_sh_r <= 9'h000;
                    if (asyn && rx_fall) begin
                        rx_state_r <= RX_BUSY;
                        rx_cnt_r <= 4'h0;
                    end else if (sync && samp_ev && !rx_f_r) begin
                        rx_state_r <= RX_BUSY;
                        rx_cnt_r <= 4'h1;
                    end
                end
                RX_BUSY: begin
                    if (asyn && tick) begin
                        rx_ph_r <= !rx_ph_r;
                    end
                    if (samp) begin
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (spi || (rx_cnt_r != 4'h0 &&
                                    rx_cnt_r <= nbits)) begin
                            rx_sh_r[rx_idx] <= rx_f_r;
                        end
                        if (rx_cnt_r == nbits + 4'h1) begin
                            rx_pbit_r <= rx_f_r;
                        end
                        if (rx_false || rx_cnt_r == rx_total - 4'h1) begin
                            rx_state_r <= RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // receive buffer: a full buffer keeps its word, the newer is dropped
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            rx_valid_r <= 1'b0;
            rx_data_r <= 9'h000;
            rx_perr_r <= 1'b0;
        end else if (!rxen_r) begin
            rx_valid_r <= 1'b0;
        end else if (rx_push && (!rx_valid_r || rd_data)) begin
            rx_valid_r <= 1'b1;
            rx_data_r <= rx_word;
            rx_perr_r <= par_en && ufcb_parity(rx_word, nbits,
                             frame_r[FRM_PODD]) != rx_pbit_r;
        end else if (rd_data) begin
            rx_valid_r <= 1'b0;
        end
    end

    assign RX_START_IRQ_O = rxsie_r && GLOBAL_IRQ_EN_I && rxs_r;
    assign RX_COMPLETE_IRQ_O = rxcie_r && GLOBAL_IRQ_EN_I && rx_valid_r;
    assign WAKE_O = sfde_r && GLOBAL_IRQ_EN_I &&
                    ((rxsie_r && rxs_r) || (rxcie_r && rx_valid_r));

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    start_sticky_a: assert property (
        rxs_r && !(wr_det && HWDATA_I[SD_RXS]) |=> rxs_r)
        else $error("start flag dropped without a clear");
    start_irq_a: assert property (
        RX_START_IRQ_O |-> rxs_r && rxsie_r && GLOBAL_IRQ_EN_I)
        else $error("start irq without all enables");
    wake_off_a: assert property (!sfde_r |-> !WAKE_O)
        else $error("wake while detector off");
    det_low_zero_a: assert property (
        dp_rd_r && dp_ok_r && dp_idx_r == IDX_DETECT |-> HRDATA_O[4:0] == 0)
        else $error("reserved detect bits not zero");
    div_reload_a: assert property (
        wr_lo[0] |=> cnt_r[0] == {div_hi_r[0], $past(HWDATA_I[7:0])})
        else $error("low write did not reload prescaler");
    tick_reload_a: assert property (
        tick && !wr_lo[0] && !wr_hi[0] |=>
        cnt_r[0] == {div_hi_r[0], div_lo_r[0]})
        else $error("prescaler not reloaded at zero");
    spi_half_a: assert property (
        spi && {div_hi_r[0], div_lo_r[0]} == 0 && tx_left_r != 0 && !wr_lo[0]
        |=> tick ##1 tick)
        else $error("spi clock slower than half system clock");
    rx_flush_a: assert property (!rxen_r |=> !rx_valid_r)
        else $error("receive buffer not flushed");
    spi_parity_a: assert property (spi |-> !par_en)
        else $error("parity active in spi mode");
    sync_edge_a: assert property (
        sync && shift_ev && !wr_frame |=> XCK_O == !frame_r[FRM_CPOL])
        else $error("sync data change on wrong clock edge");
    stop_len_a: assert property (
        tx_load && !spi |=> tx_left_r == 5'(tx_len))
        else $error("frame length wrong");

    spi_done_c: cover property (spi && tx_done);
    uart_rx_c: cover property (!spi && rx_push);
    start_flag_c: cover property ($rose(rxs_r));
    wake_c: cover property ($rose(WAKE_O));
endmodule : ufcb_top

// [dv/ufcb_remote.sv]
module ufcb_remote (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic xck_i,
    input wire logic spi_i,
    input wire logic [7:0] bitp_i,
    input wire logic [7:0] spi_byte_i,
    output logic rxd_o,
    output logic [11:0] frame_o,
    output logic got_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    logic [7:0] sh = 8'h00;
    initial begin
        rxd_o = 1'b1;
        got_o = 1'b0;
        frame_o = 12'h000;
    end
    // uart listener: after a start fall, mid-bit samples of 12 bits
    always begin
        @(negedge txd_i iff !spi_i);
        repeat (bitp_i / 2) @(posedge clk_i);
        for (int i = 0; i < 12; i++) begin
            repeat (bitp_i) @(posedge clk_i);
            frame_o[i] = txd_i;
        end
        got_o = ~got_o;
    end
    // spi mode 0: sample on rising edge, change on falling edge
    always @(posedge xck_i) begin
        if (spi_i) begin
            sh = {sh[6:0], txd_i};
            n++;
            if (n == 8) begin
                frame_o = {4'h0, sh};
                n = 0;
                got_o = ~got_o;
            end
        end
    end
    // after the last bit the line is released: show the inverse
    always @(negedge xck_i) begin
        if (spi_i) begin
            rxd_o <= (n == 0) ? ~rxd_o : spi_byte_i[7 - n];
        end
    end
    always @(posedge spi_i) begin
        rxd_o <= spi_byte_i[7];
    end
    // one 8-bit frame with the given parity bit and one stop bit
    task automatic send(input logic [7:0] d, input logic par);
        logic [10:0] f;
        f = {1'b1, par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd_o <= f[i];
            repeat (bitp_i) @(posedge clk_i);
        end
    endtask : send
endmodule : ufcb_remote

// [dv/ufcb_top_test.sv]
module ufcb_top_test import ufcb_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, hwrite = 0, xdir = 0, gie = 0, spi = 0;
    logic [1:0] htrans = 2'h0;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, rnd = 32'h0000_b23c;
    logic hready, txd, xck, xoe, rxd, sirq, cirq, wake, tick, got, rdp = 0;
    logic [11:0] frame;
    logic [7:0] sbyte = 8'h00, bitp = 8'h08;
    int err_count = 0, cmp_count = 0, cyc = 0, n;
    logic [31:0] rq[$];
    logic [11:0] tq[$];
    logic [7:0] ixs [7] = '{IDX_FRAME, IDX_DIV0_LO, IDX_DIV0_HI, IDX_DETECT,
        IDX_DIV1_LO, IDX_DIV1_HI, 8'h30};
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [1:0] pms [6] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3};
    int nbs [6] = '{5, 6, 7, 8, 8, 9};
    always #12.5 clk = ~clk;
    ufcb_top ufcb_top_inst (.CLK_SYS_I(clk), .RST_I(rst), .HSEL_I(1'b1),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .RXD_I(rxd),
        .TXD_O(txd), .XCK_O(xck), .XCK_OE_O(xoe), .XCK_DIR_I(xdir),
        .GLOBAL_IRQ_EN_I(gie), .RX_START_IRQ_O(sirq),
        .RX_COMPLETE_IRQ_O(cirq), .WAKE_O(wake), .BAUD1_TICK_O(tick));
    ufcb_remote ufcb_remote_inst (.clk_i(clk), .txd_i(txd), .xck_i(xck),
        .spi_i(spi), .bitp_i(bitp), .spi_byte_i(sbyte), .rxd_o(rxd),
        .frame_o(frame), .got_o(got));
    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    task automatic bus(input logic [7:0] ix, input logic w,
            input logic [7:0] d, input logic [7:0] e);
        htrans <= 2'h2;
        haddr <= {2'h0, ix, 2'h0};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        if (!w) rq.push_back({24'h00_0000, e});
        do @(posedge clk); while (hready !== 1'b1);
    endtask : bus
    function automatic logic [31:0] nxt(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : nxt
    function automatic logic [11:0] expf(input logic [8:0] d, input int nb,
            input logic [1:0] pm);
        logic [11:0] v;
        logic p;
        v = 12'hfff;
        p = pm[0];
        for (int i = 0; i < nb; i++) begin
            v[i] = d[i];
            p ^= d[i];
        end
        if (pm[1]) v[nb] = p;
        return v;
    endfunction : expf
    // read data taken at the edge that ends the data phase
    always @(posedge clk) begin
        if (rdp && hready) begin
            chk("hrdata", hrdata, rq.pop_front());
        end
        if (hready) rdp <= htrans[1] & ~hwrite;
    end
    always @(got) begin
        if (cyc > 0) chk("frame", frame, tq.pop_front());
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        chk("xck oe", xoe, 0);
        for (int i = 0; i < 7; i++) begin
            bus(ixs[i], 0, 0, (i == 0) ? FRAME_RST : REG_RST);
        end
        bus(IDX_DETECT, 1, 8'hff, 0);
        bus(IDX_DETECT, 0, 0, 8'ha0);
        bus(IDX_DIV0_HI, 1, 8'h0a, 0);
        bus(IDX_DIV0_HI, 0, 0, 8'h0a);
        bus(IDX_DIV0_HI, 1, 8'h00, 0);
        rnd = nxt(rnd);
        bus(IDX_DIV1_HI, 1, 8'h01, 0);
        bus(IDX_DIV1_LO, 1, rnd[7:0], 0);
        bus(IDX_DIV1_LO, 0, 0, rnd[7:0]);
        do @(posedge clk); while (tick !== 1'b1);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1);
        chk("tick period", n, 257 + rnd[7:0]);
        bus(IDX_DIV0_LO, 1, 8'h03, 0);
        for (int i = 0; i < 6; i++) begin
            rnd = nxt(rnd);
            bus(IDX_FRAME, 1, {2'h0, pms[i], i[0], codes[i][1:0], 1'b0},
                0);
            bus(IDX_XFER, 1, {5'h13, codes[i][2], 1'b0, rnd[8]}, 0);
            tq.push_back(expf(rnd[8:0], nbs[i], pms[i]));
            bus(IDX_DATA, 1, rnd[7:0], 0);
            while (tq.size() != 0) @(posedge clk);
            repeat (16) @(posedge clk);
        end
        bus(IDX_STATUS, 1, 8'h40, 0);
        // back to eight data bits for the received frames
        bus(IDX_XFER, 1, 8'h98, 0);
        bus(IDX_FRAME, 1, 8'h26, 0);
        gie <= 1;
        for (int k = 0; k < 2; k++) begin
            rnd = nxt(rnd);
            ufcb_remote_inst.send(rnd[7:0], ^rnd[7:0] ^ k[0]);
            while (cirq !== 1'b1) @(posedge clk);
            chk("start irq", sirq, 1);
            chk("wake", wake, 1);
            bus(IDX_STATUS, 0, 0, {5'h14, k[0], 2'h0});
            bus(IDX_DATA, 0, 0, rnd[7:0]);
            @(posedge clk);
            chk("complete irq", cirq, 0);
        end
        gie <= 0;
        repeat (2) @(posedge clk);
        chk("start irq off", sirq, 0);
        gie <= 1;
        bus(IDX_DETECT, 1, 8'he0, 0);
        @(posedge clk);
        chk("start flag clear", sirq, 0);
        sbyte <= rnd[15:8];
        xdir <= 1;
        bus(IDX_FRAME, 1, 8'hc0, 0);
        spi <= 1;
        bus(IDX_DIV0_LO, 1, 8'h07, 0);
        chk("xck oe", xoe, 1);
        tq.push_back({4'h0, rnd[7:0]});
        bus(IDX_DATA, 1, rnd[7:0], 0);
        while (tq.size() != 0) @(posedge clk);
        while (cirq !== 1'b1) @(posedge clk);
        bus(IDX_DATA, 0, 0, rnd[15:8]);
        // fastest transfer clock: divisor zero, transmit side only
        bus(IDX_DIV0_LO, 1, 8'h00, 0);
        tq.push_back({4'h0, rnd[23:16]});
        bus(IDX_DATA, 1, rnd[23:16], 0);
        while (tq.size() != 0) @(posedge clk);
        spi <= 0;
        bus(IDX_FRAME, 1, 8'h40, 0);
        repeat (4) @(posedge clk);
        chk("xck oe sync", xoe, 1);
        final_report();
    end
endmodule : ufcb_top_test
